// *** hfa_tx_dev.sv ***
// Device end: shared buffer split and transmit data path with status FIFO.
// How it works
// - TX total minus fixed 512-byte status FIFO.
// - Total TX allocation never below 2KB.
// - Receive side gets 16384 minus TX total.
// - RX status is one sixteenth of RX.
// - Commands and payload both fill TX data FIFO.
// - Host programs TX size 2 to 14 only.
// - RX data full four DWORDs before capacity.
// - Each buffer opens with command A, B.
// - Packet tag copied into TX status word.
// - Differing tags in one packet flag error.
// - Payload byte count mismatching length flags error.
// - Host repeats packet length in every buffer.
// - Payload starts at offset, earlier bytes dropped.
// - Every buffer may start at any byte.
// - End padding DWORDs accepted and discarded.
// - Completion interrupt after buffer loaded and sent.
// - One status word per finished transmission.
// - Interrupt when status count reaches programmed level.
// - Overfilling the TX data FIFO flags error.
// - Host writes command A, B, then payload.
`include "hfa_cfg.svh"
module hfa_tx_dev #(
  parameter int DEPTH_W    = 3456,
  parameter int STS_DEPTH  = 128,
  parameter int TAGQ_DEPTH = 4
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Host link.
  hfa_bus_if.dev           bus,
  // Transmit MAC stream.
  output logic      [31:0] mac_data,
  output logic      [3:0]  mac_be,
  output logic             mac_valid,
  output logic             mac_last,
  input  wire logic        mac_ready,
  input  wire logic        mac_done,
  input  wire logic        mac_fail,
  // Receive fill level and buffer sizing.
  input  wire logic [15:0] rx_level_dw,
  output logic             rx_data_full,
  output logic      [15:0] tx_data_bytes,
  output logic      [15:0] rx_data_bytes,
  output logic      [15:0] rx_status_bytes
);
  localparam int AW = $clog2(DEPTH_W);
  localparam int SW = $clog2(STS_DEPTH);
  localparam int TW = $clog2(TAGQ_DEPTH);

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [15:0] tx_total(input logic [3:0] sel);
    tx_total = 16'({sel, 10'h000});
  endfunction

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(DEPTH_W - 1)) ? '0 : p + AW'(1);
  endfunction

  function automatic logic [3:0] lane_mask(input logic [11:0] widx, input logic [4:0] off,
                                           input logic [10:0] size);
    logic [13:0] p;
    logic [13:0] endp;
    lane_mask = 4'h0;
    endp = 14'(off) + 14'(size);
    for (int k = 0; k < 4; k++) begin
      p = {widx, 2'b00} + 14'(k);
      lane_mask[k] = (p >= 14'(off)) && (p < endp);
    end
  endfunction

  function automatic logic [11:0] align_words(input logic [11:0] n, input logic [1:0] al);
    logic [11:0] m;
    m = (al == 2'b01) ? 12'h004 : (al == 2'b10) ? 12'h008 : 12'h001;
    align_words = (n + m - 12'h001) & ~(m - 12'h001);
  endfunction

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [31:0]   dmem [DEPTH_W];
  logic [31:0]   smem [STS_DEPTH];
  logic [17:0]   tqm  [TAGQ_DEPTH];
  logic [31:0]   rdata_q, cmda_q, mdata_q, word;
  logic [17:0]   tq_head;
  logic [15:0]   txd_q, rxd_q, rxs_q, used_q, tag_q, cap_w;
  logic [11:0]   cnt_q, widx_q, nword_q, cnt_new, nw_calc;
  logic [10:0]   len_q;
  logic [AW-1:0] wp_q, rp_q;
  logic [SW-1:0] swp_q, srp_q;
  logic [SW:0]   txs_lvl_q, scnt_q;
  logic [TW-1:0] twp_q, trp_q;
  logic [TW:0]   tcnt_q;
  logic [3:0]    sel_q, mbe_q, mask;
  logic [2:0]    int_en_q, int_sts_q, int_set, int_d;
  logic          ack_q, irq_q, idle_q, rx_full_q, perr_q, pioc_q, mvalid_q, mlast_q;
  logic          wstb, rstb, dport, push, ovf, pop, pop_a, pop_b, pop_d, pkt_end, tag_bad, len_bad, sts_push, sts_pop;
  hfa_pkg::hfa_tx_st_t st_q;

  // ****************************************************************
  // Link decode and allocation.
  // ****************************************************************
  assign wstb    = bus.req & bus.we & ~ack_q;
  assign rstb    = bus.req & ~bus.we & ~ack_q;
  assign dport   = bus.addr <= `HFA_OFS_TXD_END;
  assign cap_w   = txd_q >> 2;
  assign push    = wstb & dport & (used_q < cap_w);
  assign ovf     = wstb & dport & (used_q >= cap_w);
  assign word    = dmem[rp_q];
  assign pop     = (used_q != 16'h0) & (~mvalid_q | mac_ready) & (tcnt_q < (TW+1)'(TAGQ_DEPTH));
  assign sts_pop = rstb & (bus.addr == `HFA_OFS_TXS_POP) & (scnt_q != '0);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_q     <= `HFA_SEL_RST;
      int_en_q  <= 3'h0;
      txs_lvl_q <= '0;
    end else if (wstb) begin
      if (bus.addr == `HFA_OFS_HARDWARE_CONFIG_REG) begin
        if (bus.wdata[`HFA_CFG_SEL] >= `HFA_SEL_MIN && bus.wdata[`HFA_CFG_SEL] <= `HFA_SEL_MAX) begin
          sel_q <= bus.wdata[`HFA_CFG_SEL];
        end
      end else if (bus.addr == `HFA_OFS_INT_EN) begin
        int_en_q <= bus.wdata[2:0];
      end else if (bus.addr == `HFA_OFS_TXS_LVL) begin
        txs_lvl_q <= bus.wdata[SW:0];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txd_q     <= 16'h0;
      rxd_q     <= 16'h0;
      rxs_q     <= 16'h0;
      rx_full_q <= 1'b0;
    end else begin
      txd_q     <= tx_total(sel_q) - `HFA_TXS_BYTES;
      rxs_q     <= (`HFA_BUF_BYTES - tx_total(sel_q)) >> 4;
      rxd_q     <= (`HFA_BUF_BYTES - tx_total(sel_q)) - ((`HFA_BUF_BYTES - tx_total(sel_q)) >> 4);
      rx_full_q <= rx_level_dw + `HFA_RXD_GUARD_DW >= (rxd_q >> 2);
    end
  end

  // ****************************************************************
  // Link answer.
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= bus.req & ~ack_q;
      if (rstb) begin
        if (bus.addr == `HFA_OFS_TXS_POP || bus.addr == `HFA_OFS_TXS_PEEK) begin
          rdata_q <= (scnt_q != '0) ? smem[srp_q] : 32'h0;
        end else if (bus.addr == `HFA_OFS_INT_STS) begin
          rdata_q <= {29'h0, int_sts_q};
        end else if (bus.addr == `HFA_OFS_INT_EN) begin
          rdata_q <= {29'h0, int_en_q};
        end else if (bus.addr == `HFA_OFS_HARDWARE_CONFIG_REG) begin
          rdata_q <= {12'h0, sel_q, 16'h0};
        end else if (bus.addr == `HFA_OFS_TX_INFO) begin
          rdata_q <= {8'h0, 8'(scnt_q), (cap_w - used_q) << 2};
        end else if (bus.addr == `HFA_OFS_TXS_LVL) begin
          rdata_q <= 32'(txs_lvl_q);
        end else if (bus.addr == `HFA_OFS_SIZES) begin
          rdata_q <= {rxd_q, txd_q};
        end else begin
          rdata_q <= 32'h0;
        end
      end
    end
  end

  // ****************************************************************
  // Transmit data FIFO.
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (push) begin
      dmem[wp_q] <= bus.wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wp_q   <= '0;
      rp_q   <= '0;
      used_q <= 16'h0;
    end else begin
      if (push) begin
        wp_q <= ptr_next(wp_q);
      end
      if (pop) begin
        rp_q <= ptr_next(rp_q);
      end
      used_q <= used_q + 16'(push) - 16'(pop);
    end
  end

  // ****************************************************************
  // Buffer parser.
  // ****************************************************************
  assign pop_a    = pop && (st_q == hfa_pkg::HFA_ST_CMDA);
  assign pop_b    = pop && (st_q == hfa_pkg::HFA_ST_CMDB);
  assign pop_d    = pop && (st_q == hfa_pkg::HFA_ST_DATA);
  assign mask     = lane_mask(widx_q, cmda_q[`HFA_A_OFF], cmda_q[`HFA_A_SIZE]);
  assign cnt_new  = cnt_q + 12'($countones(mask));
  assign nw_calc  = 12'((14'(cmda_q[`HFA_A_OFF]) + 14'(cmda_q[`HFA_A_SIZE]) + 14'h0003) >> 2);
  // A packet closes on its last payload word, so status never waits on padding.
  assign pkt_end  = pop_d && cmda_q[`HFA_A_LAST] && (widx_q == nw_calc - 12'h001);
  assign tag_bad  = pop_b && !cmda_q[`HFA_A_FIRST] && (word[`HFA_B_TAG] != tag_q);
  assign len_bad  = pkt_end && (cnt_new != 12'(len_q));
  assign tq_head  = tqm[trp_q];
  assign sts_push = (mac_done | mac_fail) && (tcnt_q != '0) && (scnt_q < (SW+1)'(STS_DEPTH));
  assign int_set  = {ovf | tag_bad | len_bad, (txs_lvl_q != '0) && (scnt_q >= txs_lvl_q),
                     sts_push & tq_head[1]};
  assign int_d    = int_set | (int_sts_q & ~((wstb && bus.addr == `HFA_OFS_INT_STS) ? bus.wdata[2:0] : 3'h0));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q   <= hfa_pkg::HFA_ST_CMDA;
      cnt_q  <= 12'h0;
      widx_q <= 12'h0;
      perr_q <= 1'b0;
      pioc_q <= 1'b0;
    end else if (pop) begin
      case (st_q)
        hfa_pkg::HFA_ST_CMDA: begin
          st_q <= hfa_pkg::HFA_ST_CMDB;
        end
        hfa_pkg::HFA_ST_CMDB: begin
          cnt_q  <= cmda_q[`HFA_A_FIRST] ? 12'h0 : cnt_q;
          perr_q <= tag_bad | (perr_q & ~cmda_q[`HFA_A_FIRST]);
          pioc_q <= cmda_q[`HFA_A_IOC] | (pioc_q & ~cmda_q[`HFA_A_FIRST]);
          widx_q <= 12'h0;
          st_q   <= hfa_pkg::HFA_ST_DATA;
        end
        default: begin
          cnt_q  <= cnt_new;
          widx_q <= widx_q + 12'h001;
          if (widx_q == nword_q - 12'h001) begin
            st_q <= hfa_pkg::HFA_ST_CMDA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (pop_a) begin
      cmda_q <= word;
    end
    if (pop_b) begin
      nword_q <= align_words(nw_calc, cmda_q[`HFA_A_ALIGN]);
    end
    if (pop_b && cmda_q[`HFA_A_FIRST]) begin
      tag_q <= word[`HFA_B_TAG];
      len_q <= word[`HFA_B_LEN];
    end
    if (pop_d) begin
      mdata_q <= word;
      mbe_q   <= mask;
    end
    if (pkt_end) begin
      tqm[twp_q] <= {tag_q, pioc_q, perr_q | len_bad};
    end
    if (sts_push) begin
      smem[swp_q] <= {tq_head[17:2], 15'h0000, mac_fail | tq_head[0]};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mvalid_q  <= 1'b0;
      mlast_q   <= 1'b0;
      twp_q     <= '0;
      trp_q     <= '0;
      tcnt_q    <= '0;
      swp_q     <= '0;
      srp_q     <= '0;
      scnt_q    <= '0;
      int_sts_q <= 3'h0;
      irq_q     <= 1'b0;
      idle_q    <= 1'b0;
    end else begin
      mvalid_q  <= pop_d ? (mask != 4'h0) : (mvalid_q & ~mac_ready);
      mlast_q   <= pop_d ? pkt_end : mlast_q;
      twp_q     <= twp_q + TW'(pkt_end);
      trp_q     <= trp_q + TW'(sts_push);
      tcnt_q    <= tcnt_q + (TW+1)'(pkt_end) - (TW+1)'(sts_push);
      swp_q     <= swp_q + SW'(sts_push);
      srp_q     <= srp_q + SW'(sts_pop);
      scnt_q    <= scnt_q + (SW+1)'(sts_push) - (SW+1)'(sts_pop);
      int_sts_q <= int_d;
      irq_q     <= (int_sts_q & int_en_q) != 3'h0;
      idle_q    <= (used_q == 16'h0) && (tcnt_q == '0) && !mvalid_q && (st_q == hfa_pkg::HFA_ST_CMDA);
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.ack = ack_q;
  assign bus.irq = irq_q;
  assign bus.idle = idle_q;
  assign mac_data = mdata_q;
  assign mac_be = mbe_q;
  assign mac_valid = mvalid_q;
  assign mac_last = mlast_q;
  assign rx_data_full = rx_full_q;
  assign tx_data_bytes = txd_q;
  assign rx_data_bytes = rxd_q;
  assign rx_status_bytes = rxs_q;
endmodule

// *** hfa_cfg.svh ***
// Constants shared by the host-FIFO allocation and transmit path ends.
`ifndef HFA_CFG_SVH
`define HFA_CFG_SVH

// ****************************************************************
// Buffer allocation.
// ****************************************************************
`define HFA_BUF_BYTES     16'h4000
`define HFA_TXS_BYTES     16'h0200
`define HFA_SEL_MIN       4'h2
`define HFA_SEL_MAX       4'he
`define HFA_SEL_RST       4'h5
`define HFA_RXD_GUARD_DW  16'h0004

// ****************************************************************
// Register offsets on the device link, plus the host-local status address.
// ****************************************************************
`define HFA_OFS_TXD_END   8'h1c
`define HFA_OFS_TXS_POP   8'h48
`define HFA_OFS_TXS_PEEK  8'h4c
`define HFA_OFS_INT_STS   8'h58
`define HFA_OFS_INT_EN    8'h5c
`define HFA_OFS_HARDWARE_CONFIG_REG    8'h74
`define HFA_OFS_TX_INFO   8'h80
`define HFA_OFS_TXS_LVL   8'h84
`define HFA_OFS_SIZES     8'h88
`define HFA_HOST_STS      9'h100

// ****************************************************************
// Fields.
// ****************************************************************
`define HFA_CFG_SEL       19:16
`define HFA_A_IOC         31
`define HFA_A_ALIGN       25:24
`define HFA_A_OFF         20:16
`define HFA_A_FIRST       13
`define HFA_A_LAST        12
`define HFA_A_SIZE        10:0
`define HFA_B_TAG         31:16
`define HFA_B_LEN         10:0
`define HFA_INT_IOC       0
`define HFA_INT_LVL       1
`define HFA_INT_TXE       2
`define HFA_HS_REFUSED    2
`endif

// *** hfa_pkg.sv ***
// Types shared by both ends of the transmit FIFO link.
package hfa_pkg;
  typedef enum logic [1:0] {
    HFA_ST_CMDA = 2'b00,
    HFA_ST_CMDB = 2'b01,
    HFA_ST_DATA = 2'b11
  } hfa_tx_st_t;

  typedef enum logic [1:0] {
    HFA_HB_IDLE = 2'b00,
    HFA_HB_REQ  = 2'b01,
    HFA_HB_DONE = 2'b11
  } hfa_hb_st_t;
endpackage

// *** hfa_bus_if.sv ***
// Register link between the host bridge and the transmit FIFO device.
interface hfa_bus_if;
  logic        req;
  logic        we;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  logic        irq;
  logic        idle;

  modport dev (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output rdata,
    output ack,
    output irq,
    output idle
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input  rdata,
    input  ack,
    input  irq,
    input  idle
  );
endinterface

// *** hfa_tx_host.sv ***
// Host end: Wishbone slave that forwards accesses onto the device link and answers local and refused ones itself.
`include "hfa_cfg.svh"
module hfa_tx_host (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Wishbone slave.
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [8:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  // Device link.
  hfa_bus_if.host          bus,
  // Interrupt from the device.
  output logic             irq
);
  hfa_pkg::hfa_hb_st_t st_q;
  logic        req_q;
  logic        we_q;
  logic [7:0]  addr_q;
  logic [31:0] wdata_q;
  logic [31:0] dat_r_q;
  logic        ack_q;
  logic        refused_q;
  logic        irq_q;
  logic        take;
  logic        local_hit;
  logic        bad_cfg;
  logic        refuse;

  // ****************************************************************
  // Request classification.
  // ****************************************************************
  assign take      = wb_cyc & wb_stb & ~ack_q & (st_q == hfa_pkg::HFA_HB_IDLE);
  assign local_hit = wb_adr[8];
  // A size change must be legal and only happens on an idle device.
  assign bad_cfg   = (wb_adr[7:0] == `HFA_OFS_HARDWARE_CONFIG_REG) &&
                     ((wb_dat_w[`HFA_CFG_SEL] < `HFA_SEL_MIN) ||
                      (wb_dat_w[`HFA_CFG_SEL] > `HFA_SEL_MAX) || ~bus.idle);
  assign refuse    = wb_we & ((wb_sel != 4'hf) | bad_cfg);

  // ****************************************************************
  // Bridge sequence.
  // ****************************************************************
  // Accesses go out one at a time in issue order, so command A, command B
  // and payload reach the device exactly as software wrote them.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q    <= hfa_pkg::HFA_HB_IDLE;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= 8'h00;
      wdata_q <= 32'h0;
      dat_r_q <= 32'h0;
      ack_q   <= 1'b0;
    end else begin
      case (st_q)
        hfa_pkg::HFA_HB_IDLE: begin
          if (take && (local_hit || refuse)) begin
            dat_r_q <= {29'h0, refused_q, bus.idle, bus.irq};
            ack_q   <= 1'b1;
            st_q    <= hfa_pkg::HFA_HB_DONE;
          end else if (take) begin
            req_q   <= 1'b1;
            we_q    <= wb_we;
            addr_q  <= wb_adr[7:0];
            wdata_q <= wb_dat_w;
            st_q    <= hfa_pkg::HFA_HB_REQ;
          end
        end
        hfa_pkg::HFA_HB_REQ: begin
          if (bus.ack) begin
            req_q   <= 1'b0;
            dat_r_q <= bus.rdata;
            ack_q   <= 1'b1;
            st_q    <= hfa_pkg::HFA_HB_DONE;
          end
        end
        default: begin
          ack_q <= 1'b0;
          st_q  <= hfa_pkg::HFA_HB_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Local status and interrupt.
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      refused_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      irq_q <= bus.irq;
      if (take && !local_hit && refuse) begin
        refused_q <= 1'b1;
      end else if (take && local_hit && wb_we && wb_dat_w[`HFA_HS_REFUSED]) begin
        refused_q <= 1'b0;
      end
    end
  end

  assign bus.req   = req_q;
  assign bus.we    = we_q;
  assign bus.addr  = addr_q;
  assign bus.wdata = wdata_q;
  assign wb_dat_r  = dat_r_q;
  assign wb_ack    = ack_q;
  assign irq       = irq_q;
endmodule

// *** hfa_tx_monitor.sv ***
// Concurrent checks on the link between the host bridge and the transmit device.
`include "hfa_cfg.svh"
module hfa_tx_monitor (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        rst,
  // Link signals.
  input wire logic        req,
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  input wire logic        irq,
  input wire logic        idle
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic       cfg_rd;
  logic [3:0] sel_q;

  assign cfg_rd = ack && !we && addr == `HFA_OFS_HARDWARE_CONFIG_REG;

  // Tracks the last valid size selection written, so read-back can be judged.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_q <= `HFA_SEL_RST;
    end else if (ack && we && addr == `HFA_OFS_HARDWARE_CONFIG_REG) begin
      sel_q <= wdata[`HFA_CFG_SEL];
    end
  end

  a_ack_has_req: assert property ($rose(ack) |-> req) else $error("ack without request");
  a_req_answered: assert property ($rose(req) |-> ##[1:64] ack) else $error("request not answered");
  a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before answer");
  a_ack_one_cycle: assert property ($rose(ack) |=> !ack) else $error("ack longer than one cycle");
  a_irq_quiet_reset: assert property ($fell(rst) |-> !irq) else $error("interrupt high after reset");
  a_sel_in_range: assert property (cfg_rd |-> rdata[19:16] >= `HFA_SEL_MIN && rdata[19:16] <= `HFA_SEL_MAX)
    else $error("size selection out of range");
  a_sel_readback: assert property (cfg_rd |-> rdata[19:16] == sel_q)
    else $error("size selection read back wrong");
  a_ack_no_repeat: assert property (ack |=> !ack [*1] ##1 (!ack || req)) else $error("stray ack");
  a_cfg_when_idle: assert property (ack && we && addr == `HFA_OFS_HARDWARE_CONFIG_REG |-> idle)
    else $error("size changed while busy");
  c_cfg_read: cover property (cfg_rd);

  c_write: cover property (ack && we);
  c_pop: cover property (ack && !we && addr == `HFA_OFS_TXS_POP);
  c_irq: cover property ($rose(irq));
endmodule

// *** tb_host_fifo_alloc_tx_path.sv ***
// Testbench joining the host bridge and the transmit device through their link.
`include "hfa_cfg.svh"
module tb_host_fifo_alloc_tx_path;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst, wb_cyc, wb_stb, wb_we, wb_ack, irq, stall, fail_next;
  logic        mac_valid, mac_last, mac_ready, mac_done, mac_fail, rx_data_full;
  logic [3:0]  wb_sel, mac_be;
  logic [8:0]  wb_adr;
  logic [31:0] wb_dat_w, wb_dat_r, mac_data, q;
  logic [15:0] rx_level_dw, tx_data_bytes, rx_data_bytes, rx_status_bytes, tag;
  int          seed = 86, mismatches = 0, total_checks = 0, bytes_seen = 0, pkts = 0, exp_pkts = 0, exp_bytes = 0;

  hfa_bus_if bus_if();
  hfa_tx_host hfa_tx_host_inst (.clock(clock), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .bus(bus_if),
    .irq(irq));
  hfa_tx_dev hfa_tx_dev_inst (.clock(clock), .rst(rst), .bus(bus_if), .mac_data(mac_data), .mac_be(mac_be),
    .mac_valid(mac_valid), .mac_last(mac_last), .mac_ready(mac_ready), .mac_done(mac_done), .mac_fail(mac_fail),
    .rx_level_dw(rx_level_dw), .rx_data_full(rx_data_full), .tx_data_bytes(tx_data_bytes),
    .rx_data_bytes(rx_data_bytes), .rx_status_bytes(rx_status_bytes));
  hfa_tx_monitor hfa_tx_monitor_inst (.clock(clock), .rst(rst), .req(bus_if.req), .we(bus_if.we),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack), .irq(bus_if.irq),
    .idle(bus_if.idle));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // The transmit side stalls at random and reports the end of each frame a cycle later.
  always @(posedge clock) begin
    mac_ready <= !stall && ($random(seed) % 4 != 0);
    mac_done <= 1'b0;
    mac_fail <= 1'b0;
    if (mac_valid === 1'b1 && mac_ready) begin
      bytes_seen <= bytes_seen + $countones(mac_be);
      if (mac_last) begin
        pkts <= pkts + 1;
        mac_done <= !fail_next;
        mac_fail <= fail_next;
      end
    end
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {1'b0, a};
    wb_dat_w <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 300);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk("wishbone ack", 1, {31'h0, n < 300});
  endtask

  task sizes_for(input int sel);
    int rx;
    rx = 16384 - sel * 1024;
    xfer(1'b1, `HFA_OFS_HARDWARE_CONFIG_REG, sel << 16);
    xfer(1'b0, `HFA_OFS_HARDWARE_CONFIG_REG, 32'h0);
    chk("tx_alloc_select", sel, {28'h0, q[19:16]});
    rx_level_dw <= 16'(rx * 15 / 64 - 5);
    repeat (3) @(posedge clock);
    chk("tx_data_bytes", sel * 1024 - 512, {16'h0, tx_data_bytes});
    chk("rx_data_bytes", rx * 15 / 16, {16'h0, rx_data_bytes});
    chk("rx_status_bytes", rx / 16, {16'h0, rx_status_bytes});
    chk("rx_data_full low", 0, {31'h0, rx_data_full});
    rx_level_dw <= 16'(rx * 15 / 64 - 4);
    repeat (3) @(posedge clock);
    chk("rx_data_full high", 1, {31'h0, rx_data_full});
  endtask

  task send_buf(input logic ioc, first, last, input logic [4:0] off, input logic [1:0] al,
                input logic [10:0] sz, input logic [15:0] t, input logic [10:0] len);
    int dw, unit;
    unit = al == 2'h0 ? 1 : (al == 2'h1 ? 4 : 8);
    dw = (int'(off) + int'(sz) + 3) / 4;
    dw = (dw + unit - 1) / unit * unit;
    xfer(1'b1, `HFA_OFS_TXD_END, {ioc, 5'h0, al, 3'h0, off, 2'h0, first, last, 1'b0, sz});
    xfer(1'b1, `HFA_OFS_TXD_END, {t, 5'h0, len});
    for (int i = 0; i < dw; i++) xfer(1'b1, `HFA_OFS_TXD_END, $random(seed));
  endtask

  task pkt_end(input logic [15:0] t, input int nbytes);
    int n;
    n = 0;
    exp_pkts++;
    exp_bytes += nbytes;
    while (pkts < exp_pkts && n < 3000) begin
      @(posedge clock);
      n++;
    end
    repeat (4) @(posedge clock);
    chk("payload bytes", exp_bytes, bytes_seen);
    xfer(1'b0, `HFA_OFS_TXS_POP, 32'h0);
    chk("status tag", {16'h0, t}, {16'h0, q[31:16]});
    chk("status error", {31'h0, fail_next}, {31'h0, q[0]});
  endtask

  task expect_txe(input string name);
    q = 32'h0;
    for (int i = 0; i < 40 && q[`HFA_INT_TXE] !== 1'b1; i++) xfer(1'b0, `HFA_OFS_INT_STS, 32'h0);
    chk("tx_error_flag", 1, {31'h0, q[`HFA_INT_TXE]});
    xfer(1'b1, `HFA_OFS_INT_STS, 32'h7);
    $display("test %s done", name);
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    close_out;
  end

  initial begin
    {rst, stall, fail_next} = 3'b100;
    {wb_cyc, wb_stb, wb_we, mac_ready, mac_done, mac_fail} = 6'h0;
    {wb_sel, wb_adr, wb_dat_w, rx_level_dw} = {4'hf, 9'h0, 32'h0, 16'h0};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int s = 2; s <= 14; s++) sizes_for(s);
    xfer(1'b1, `HFA_OFS_HARDWARE_CONFIG_REG, 32'h10000);
    xfer(1'b0, `HFA_OFS_HARDWARE_CONFIG_REG, 32'h0);
    chk("tx_alloc_select kept", 14, {28'h0, q[19:16]});
    xfer(1'b0, 8'hf0, 32'h0);
    sizes_for(5);
    $display("test allocation done");
    xfer(1'b1, `HFA_OFS_INT_EN, 32'h1);
    send_buf(1'b1, 1'b1, 1'b1, 5'h0, 2'h0, 11'h10, 16'h1234, 11'h10);
    pkt_end(16'h1234, 16);
    for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clock);
    chk("irq on completion", 1, {31'h0, irq});
    xfer(1'b1, `HFA_OFS_INT_STS, 32'h7);
    repeat (4) @(posedge clock);
    chk("irq cleared", 0, {31'h0, irq});
    send_buf(1'b0, 1'b1, 1'b0, 5'h1, 2'h1, 11'h5, 16'h00a5, 11'hc);
    send_buf(1'b0, 1'b0, 1'b1, 5'h3, 2'h2, 11'h7, 16'h00a5, 11'hc);
    pkt_end(16'h00a5, 12);
    fail_next <= 1'b1;
    xfer(1'b1, `HFA_OFS_TXS_LVL, 32'h1);
    send_buf(1'b0, 1'b1, 1'b1, 5'h2, 2'h0, 11'h9, 16'hbeef, 11'h9);
    pkt_end(16'hbeef, 9);
    xfer(1'b0, `HFA_OFS_INT_STS, 32'h0);
    chk("status level flag", 1, {31'h0, q[`HFA_INT_LVL]});
    xfer(1'b1, `HFA_OFS_TXS_LVL, 32'h0);
    xfer(1'b1, `HFA_OFS_INT_STS, 32'h7);
    fail_next <= 1'b0;
    $display("test directed frames done");
    for (int k = 0; k < 8; k++) begin
      logic [10:0] sz;
      sz = 11'(1 + ($random(seed) & 63));
      tag = 16'($random(seed));
      send_buf(1'b0, 1'b1, 1'b1, 5'($random(seed) & 7), 2'(($random(seed) & 3) % 3), sz, tag, sz);
      pkt_end(tag, int'(sz));
    end
    $display("test random frames done");
    send_buf(1'b0, 1'b1, 1'b0, 5'h0, 2'h0, 11'h4, 16'h0001, 11'h8);
    send_buf(1'b0, 1'b0, 1'b1, 5'h0, 2'h0, 11'h4, 16'h0002, 11'h8);
    expect_txe("tag mismatch");
    send_buf(1'b0, 1'b1, 1'b1, 5'h0, 2'h0, 11'h8, 16'h0003, 11'h9);
    expect_txe("length mismatch");
    stall <= 1'b1;
    xfer(1'b1, `HFA_OFS_TXD_END, {8'h0, 8'h0, 5'h0, 11'h7ff} | 32'h2000);
    for (int i = 0; i < 1200; i++) xfer(1'b1, `HFA_OFS_TXD_END, i);
    expect_txe("overfill");
    close_out;
  end
endmodule
